/* File: ramp_seq_pkg.sv */
package ramp_seq_pkg;
  // register offsets
  localparam logic [7:0] ADDR_TRACK = 8'h03;
  localparam logic [7:0] ADDR_ON_DLY = 8'h05;
  localparam logic [7:0] ADDR_OFF_DLY = 8'h06;
  localparam logic [7:0] ADDR_LOAD_REG = 8'h08;
  localparam logic [7:0] ADDR_SP_FIRST = 8'h0b;
  localparam logic [7:0] ADDR_SP_LAST = 8'h10;
  localparam logic [7:0] ADDR_RUN = 8'h15;
  // reset values
  localparam logic [6:0] TRACK_RST = 7'h18;
  localparam logic [6:0] TRACK_RST_TERM = 7'h08;
  localparam logic [7:0] ON_DLY_RST = 8'h00;
  localparam logic [5:0] OFF_DLY_RST = 6'h0b;
  localparam logic [2:0] LOAD_REG_RST = 3'h0;
  localparam logic [15:0] SP_RST = 16'h0000;
  // field layout
  localparam int TRACK_W = 7;
  localparam int OFF_DLY_W = 6;
  localparam int LR_LSB = 5;
  localparam int SP_W = 12;
  localparam int SP_LSB = 4;
  localparam int SP_NUM = 3;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam logic [4:0] CYC_PER_US = 5'(CLK_HZ / HZ_PER_MHZ);
  localparam logic [9:0] US_PER_MS = 10'h3e8;
  localparam int STEP_MV = 10;
  localparam int LSB_UV = 2500;
  localparam logic [11:0] STEP_CODES = 12'(STEP_MV * 1000 / LSB_UV);
  localparam logic [8:0] DROOP_DIV = 9'h0fa;
  localparam logic [1:0] STEP_ROUND = 2'h3;

  typedef struct packed {
    logic [2:0] rise;
    logic fall_en;
    logic [2:0] fall;
  } track_cfg_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ON_WAIT = 6'h02,
    ST_RAMP_UP = 6'h04,
    ST_HOLD = 6'h08,
    ST_OFF_WAIT = 6'h10,
    ST_RAMP_DOWN = 6'h20
  } seq_state_type;

  // microseconds per 10 mV step for each rising rate code
  function automatic logic [7:0] rise_step_us(input logic [2:0] code);
    case (code)
      3'h0: rise_step_us = 8'hc8;
      3'h1: rise_step_us = 8'h64;
      3'h2: rise_step_us = 8'h32;
      3'h3: rise_step_us = 8'h28;
      3'h4: rise_step_us = 8'h14;
      3'h5: rise_step_us = 8'h0a;
      3'h6: rise_step_us = 8'h05;
      default: rise_step_us = 8'hc8;
    endcase
  endfunction

  function automatic logic [7:0] fall_step_us(input logic [2:0] code);
    case (code)
      3'h0: fall_step_us = 8'hc8;
      3'h1: fall_step_us = 8'h64;
      3'h2: fall_step_us = 8'h32;
      default: fall_step_us = 8'hc8;
    endcase
  endfunction

  // droop slope in units of 0.01 mV/A
  function automatic logic [8:0] droop_slope(input logic [2:0] code);
    case (code)
      3'h0: droop_slope = 9'h000;
      3'h1: droop_slope = 9'h025;
      3'h2: droop_slope = 9'h04a;
      3'h3: droop_slope = 9'h06f;
      3'h4: droop_slope = 9'h093;
      3'h5: droop_slope = 9'h0b8;
      3'h6: droop_slope = 9'h0dd;
      default: droop_slope = 9'h102;
    endcase
  endfunction
endpackage

/* File: us_tick_gen.sv */
`timescale 1ns/1ns
module us_tick_gen
  import ramp_seq_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // one-cycle pulse each microsecond
  output logic tick_out
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic tick_next;

  always_comb begin
    tick_next = (cnt_reg == CYC_PER_US - 5'h01);
    cnt_next = tick_next ? 5'h00 : cnt_reg + 5'h01;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      cnt_reg <= 5'h00;
      tick_out <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_out <= tick_next;
    end
  end
endmodule

/* File: output_ramp_sequencer.sv */
`timescale 1ns/1ns
// Summary of operation
// [R01] ramp-up starts only after the turn-on delay counted from the command
// [R02] turn-on delay is 8 bits, one millisecond per count, 0 to 255 ms
// [R03] with falling slew on, turn-off delay ends when output reaches zero
// [R04] with falling slew off, both switches open when turn-off delay expires
// [R05] pre-ramp wait equals turn-off delay minus output over falling rate
// [R06] software must keep the pre-ramp wait positive
// [R07] turn-off delay is six bits, 1 ms per count, reset 11, top bits zero
// [R08] setpoint moves in fixed 10 mV steps; step length sets the rate
// [R09] step length is divided down from the manager's master clock
// [R10] rising rate field bits 6:4 decodes 0.05 to 2.0 V/ms, bit 7 zero
// [R11] in bus terminator mode the rising rate resets to code zero
// [R12] tracking bit 3 enables controlled falling turn-off, reset enabled
// [R13] falling rate field bits 2:0 gives -0.05, -0.1, -0.2 V/ms
// [R14] eight load-regulation slopes lower output in proportion to load
// [R15] software must keep load plus charge current below overcurrent limit
// [R16] setpoints use 2.5 mV per bit across the range
// [R17] setpoint high byte goes to a shadow; low byte write commits all 16
// [R18] rising ramp stops at the target; falling ramp ends switches off
// [R19] a new command during a delay restarts from the new state's delay
module output_ramp_sequencer
  import ramp_seq_pkg::*;
#(
  parameter logic [7:0] MASTER_PER_US = 8'h01
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // commands and master clock from the power manager
  input wire logic terminator_mode_in,
  input wire logic turn_on_in,
  input wire logic turn_off_in,
  input wire logic master_clk_in,
  // target select and load measurement
  input wire logic [1:0] margin_sel_in,
  input wire logic [7:0] load_current_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  output logic [7:0] reg_rdata_out,
  // power stage
  output logic [SP_W-1:0] setpoint_out,
  output logic switches_on_out,
  output logic ramping_out
);
  default clocking seq_clk @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic us_tick;
  us_tick_gen u_tick (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .tick_out(us_tick)
  );

  // register file and read mux
  track_cfg_type track_reg, track_next;
  logic [7:0] on_dly_reg, on_dly_next;
  logic [OFF_DLY_W-1:0] off_dly_reg, off_dly_next;
  logic [2:0] lr_reg, lr_next;
  logic [15:0] sp_reg [SP_NUM];
  logic [15:0] sp_next [SP_NUM];
  logic [7:0] shadow_reg, shadow_next;
  logic [7:0] rdata_next;
  logic [7:0] sp_off;
  logic [1:0] sp_idx;

  always_comb begin
    track_next = track_reg;
    on_dly_next = on_dly_reg;
    off_dly_next = off_dly_reg;
    lr_next = lr_reg;
    shadow_next = shadow_reg;
    sp_off = reg_addr_in - ADDR_SP_FIRST;
    sp_idx = sp_off[2:1];
    for (int i = 0; i < SP_NUM; i++) begin
      sp_next[i] = sp_reg[i];
    end
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_TRACK: track_next = reg_wdata_in[TRACK_W-1:0]; // R10 R12 R13
        ADDR_ON_DLY: on_dly_next = reg_wdata_in; // R02
        ADDR_OFF_DLY: off_dly_next = reg_wdata_in[OFF_DLY_W-1:0]; // R07
        ADDR_LOAD_REG: lr_next = reg_wdata_in[7:LR_LSB]; // R14
        default: begin
          if (reg_addr_in inside {[ADDR_SP_FIRST:ADDR_SP_LAST]}) begin
            if (!sp_off[0]) begin
              shadow_next = reg_wdata_in; // R17
            end else begin
              sp_next[sp_idx] = {shadow_reg, reg_wdata_in}; // R17
            end
          end
        end
      endcase
    end
    // reads: unused bits and unmapped addresses return zero
    rdata_next = 8'h00;
    case (reg_addr_in)
      ADDR_TRACK: rdata_next = {1'b0, track_reg}; // R10
      ADDR_ON_DLY: rdata_next = on_dly_reg;
      ADDR_OFF_DLY: rdata_next = {2'b00, off_dly_reg}; // R07
      ADDR_LOAD_REG: rdata_next = {lr_reg, 5'h00};
      ADDR_RUN: rdata_next = {ramping_out, 6'h00, switches_on_out};
      default: begin
        if (reg_addr_in >= ADDR_SP_FIRST && reg_addr_in <= ADDR_SP_LAST) begin
          rdata_next = sp_off[0] ? sp_reg[sp_idx][7:0] : sp_reg[sp_idx][15:8];
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      track_reg <= terminator_mode_in ? TRACK_RST_TERM : TRACK_RST; // R11
      on_dly_reg <= ON_DLY_RST;
      off_dly_reg <= OFF_DLY_RST; // R07
      lr_reg <= LOAD_REG_RST;
      shadow_reg <= 8'h00;
      reg_rdata_out <= 8'h00;
      for (int i = 0; i < SP_NUM; i++) begin
        sp_reg[i] <= SP_RST;
      end
    end else begin
      track_reg <= track_next;
      on_dly_reg <= on_dly_next;
      off_dly_reg <= off_dly_next;
      lr_reg <= lr_next;
      shadow_reg <= shadow_next;
      reg_rdata_out <= rdata_next;
      for (int i = 0; i < SP_NUM; i++) begin
        sp_reg[i] <= sp_next[i];
      end
    end
  end

  // on/off sequencer and ramp generator
  seq_state_type state_reg, state_next;
  logic [17:0] wait_reg, wait_next;
  logic [15:0] step_cnt_reg, step_cnt_next;
  logic [SP_W-1:0] ramp_reg, ramp_next;
  logic [SP_W-1:0] set_next;
  logic sw_next;
  logic master_prev_reg;
  logic master_edge;
  logic [SP_W-1:0] target;
  logic [15:0] step_len;
  logic step_due;
  logic [17:0] on_wait_us;
  logic [17:0] off_dly_us;
  logic [17:0] fall_ramp_us;
  logic [17:0] off_wait_us;
  logic [16:0] droop_prod;
  logic [SP_W-1:0] droop_codes;
  logic is_on_state;

  always_comb begin
    target = sp_reg[(margin_sel_in < 2'(SP_NUM)) ? margin_sel_in : 2'h0]
      [15:SP_LSB]; // R16
    master_edge = master_clk_in && !master_prev_reg; // R09
    step_len = (state_reg == ST_RAMP_DOWN) ?
      16'(fall_step_us(track_reg.fall) * MASTER_PER_US) :
      16'(rise_step_us(track_reg.rise) * MASTER_PER_US); // R09 R10 R13
    step_due = master_edge && (step_cnt_reg + 16'h0001 >= step_len); // R08
    on_wait_us = 18'(on_dly_reg * US_PER_MS); // R02
    off_dly_us = 18'(off_dly_reg * US_PER_MS); // R07
    fall_ramp_us = 18'(((ramp_reg + 12'(STEP_ROUND)) >> 2) *
      fall_step_us(track_reg.fall));
    off_wait_us = (off_dly_us > fall_ramp_us) ?
      off_dly_us - fall_ramp_us : 18'h00000; // R05 R06
    is_on_state = (state_reg == ST_ON_WAIT) || (state_reg == ST_RAMP_UP) ||
      (state_reg == ST_HOLD);
    state_next = state_reg;
    wait_next = (us_tick && wait_reg != 18'h00000) ? wait_reg - 18'h00001 :
      wait_reg;
    step_cnt_next = master_edge ? step_cnt_reg + 16'h0001 : step_cnt_reg;
    if (step_due) begin
      step_cnt_next = 16'h0000;
    end
    ramp_next = ramp_reg;
    case (state_reg)
      ST_ON_WAIT: begin
        if (wait_reg == 18'h00000) begin
          state_next = ST_RAMP_UP; // R01
          step_cnt_next = 16'h0000;
        end
      end
      ST_RAMP_UP: begin
        if (ramp_reg >= target) begin
          ramp_next = target;
          state_next = ST_HOLD; // R18
        end else if (step_due) begin
          ramp_next = (target - ramp_reg > STEP_CODES) ?
            ramp_reg + STEP_CODES : target; // R08 R18
        end
      end
      ST_HOLD: ramp_next = target;
      ST_OFF_WAIT: begin
        if (wait_reg == 18'h00000) begin
          step_cnt_next = 16'h0000;
          if (track_reg.fall_en) begin
            state_next = ST_RAMP_DOWN; // R03 R12
          end else begin
            state_next = ST_IDLE; // R04
            ramp_next = '0;
          end
        end
      end
      ST_RAMP_DOWN: begin
        if (ramp_reg == '0) begin
          state_next = ST_IDLE; // R18
        end else if (step_due) begin
          ramp_next = (ramp_reg > STEP_CODES) ? ramp_reg - STEP_CODES : '0;
        end
      end
      ST_IDLE: ramp_next = '0;
      default: state_next = ST_IDLE;
    endcase
    // commands override, restarting any delay in progress except the turn-on delay, which a repeated turn-on leaves running
    if (turn_on_in && !is_on_state) begin
      state_next = ST_ON_WAIT; // R01 R19
      wait_next = on_wait_us;
    end else if (turn_off_in && (is_on_state || state_reg == ST_OFF_WAIT))
    begin
      state_next = ST_OFF_WAIT; // R19
      wait_next = track_reg.fall_en ? off_wait_us : off_dly_us; // R04 R05
    end
    droop_prod = 17'(load_current_in * droop_slope(lr_reg));
    droop_codes = 12'(droop_prod / 17'(DROOP_DIV)); // R14
    set_next = (ramp_next > droop_codes) ? ramp_next - droop_codes : '0; // R14
    sw_next = (state_next == ST_RAMP_UP) || (state_next == ST_HOLD) ||
      (switches_on_out && state_next != ST_IDLE); // R04 R18
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      wait_reg <= 18'h00000;
      step_cnt_reg <= 16'h0000;
      ramp_reg <= '0;
      master_prev_reg <= 1'b0;
      setpoint_out <= '0;
      switches_on_out <= 1'b0;
      ramping_out <= 1'b0;
    end else begin
      state_reg <= state_next;
      wait_reg <= wait_next;
      step_cnt_reg <= step_cnt_next;
      ramp_reg <= ramp_next;
      master_prev_reg <= master_clk_in;
      setpoint_out <= set_next;
      switches_on_out <= sw_next;
      ramping_out <= (state_next == ST_RAMP_UP) ||
        (state_next == ST_RAMP_DOWN);
    end
  end

  // assertions
  a_ramp_after_delay: assert property ( // R01
    (state_reg == ST_RAMP_UP && $past(state_reg) == ST_ON_WAIT) |->
      $past(wait_reg) == 18'h00000)
    else $error("ramp started before turn-on delay ended");
  a_on_delay_load: assert property ( // R02
    (turn_on_in && !is_on_state) |=>
      wait_reg == 18'($past(on_dly_reg) * US_PER_MS))
    else $error("turn-on delay not loaded in ms");
  a_off_wait_calc: assert property ( // R05
    (turn_off_in && !turn_on_in && is_on_state && track_reg.fall_en) |=>
      wait_reg == $past(off_wait_us))
    else $error("pre-ramp wait wrong");
  a_switch_off_slew: assert property ( // R04
    (state_reg == ST_OFF_WAIT && wait_reg == 18'h00000 &&
     !track_reg.fall_en && !turn_on_in && !turn_off_in) |=>
      !switches_on_out && state_reg == ST_IDLE)
    else $error("switches not opened at turn-off delay end");
  a_step_size: assert property ( // R08
    (state_reg == ST_RAMP_UP && $past(state_reg) == ST_RAMP_UP) |->
      ramp_reg - $past(ramp_reg) <= STEP_CODES)
    else $error("ramp step too large");
  a_track_bit7: assert property ( // R10
    (reg_addr_in == ADDR_TRACK) |=> reg_rdata_out[7] == 1'b0)
    else $error("tracking bit 7 not zero");
  a_off_upper_zero: assert property ( // R07
    (reg_addr_in == ADDR_OFF_DLY) |=> reg_rdata_out[7:6] == 2'b00)
    else $error("turn-off delay top bits not zero");
  a_hold_target: assert property ( // R18
    (state_reg == ST_HOLD && $past(state_reg) == ST_HOLD &&
     $stable(target)) |-> ramp_reg == target)
    else $error("hold does not track target");
  a_down_ends_off: assert property ( // R18
    (state_reg == ST_RAMP_DOWN && ramp_reg == '0 && !turn_on_in) |=>
      !switches_on_out)
    else $error("ramp-down did not end with switches off");
  a_shadow_hold: assert property ( // R17
    (reg_wr_in && reg_addr_in == ADDR_SP_FIRST) |=> $stable(sp_reg[0]))
    else $error("high byte write changed setpoint");
endmodule

/* File: power_manager_model.sv */
`timescale 1ns/1ns
module power_manager_model #(
  parameter int MASTER_HALF_NS = 500
) (
  // system clock
  input wire logic clk_in,
  // master clock and commands
  output logic master_clk_out,
  output logic turn_on_out,
  output logic turn_off_out
);
  // free-running master clock, one rising edge per microsecond
  initial begin
    master_clk_out = 1'b0;
    forever #(MASTER_HALF_NS) master_clk_out = ~master_clk_out;
  end

  initial begin
    turn_on_out = 1'b0;
    turn_off_out = 1'b0;
  end

  // commands are one-cycle pulses launched at the falling edge
  task automatic send_cmd(input logic on);
    @(negedge clk_in);
    if (on) begin
      turn_on_out = 1'b1;
    end else begin
      turn_off_out = 1'b1;
    end
    @(negedge clk_in);
    turn_on_out = 1'b0;
    turn_off_out = 1'b0;
  endtask
endmodule

/* File: output_ramp_sequencer_tb.sv */
`timescale 1ns/1ns
module output_ramp_sequencer_tb;
  import ramp_seq_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in;
  logic term;
  logic mclk, t_on, t_off, sw, ramp;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic [7:0] load;
  logic [1:0] msel;
  logic [7:0] rdata, v;
  logic [SP_W-1:0] sp, sp_last;
  logic rd_chk = 1'b0;
  logic watch_sp = 1'b0;
  logic [7:0] rd_q[$];
  logic [SP_W-1:0] sp_q[$];
  logic [8:0] slope[8] = '{9'h000, 9'h025, 9'h04a, 9'h06f, 9'h093,
    9'h0b8, 9'h0dd, 9'h102};
  int n_errors = 0;
  int checks_done = 0;
  int per_cyc = 0;
  int n;
  time prev_t = 0;

  always #25 clk_in = ~clk_in;

  power_manager_model pm (.clk_in(clk_in), .master_clk_out(mclk),
    .turn_on_out(t_on), .turn_off_out(t_off));

  output_ramp_sequencer #(.MASTER_PER_US(8'h01)) dut (
    .clk_in(clk_in), .reset_in(reset_in), .terminator_mode_in(term),
    .turn_on_in(t_on), .turn_off_in(t_off), .master_clk_in(mclk),
    .margin_sel_in(msel), .load_current_in(load), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rdata_out(rdata),
    .setpoint_out(sp), .switches_on_out(sw), .ramping_out(ramp));

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic near(input int got, input int exp, input int tol);
    compare(16'((got > exp - tol && got < exp + tol) ? exp : got),
      16'(exp));
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_in);
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    addr = a;
    rd_q.push_back(e);
    @(negedge clk_in);
    rd_chk = 1'b1;
    @(negedge clk_in);
    rd_chk = 1'b0;
  endtask

  task automatic wait_for(input bit on_sw, input logic lvl, input int maxc);
    n = 0;
    while ((on_sw ? sw : ramp) !== lvl && n < maxc) begin
      @(negedge clk_in);
      n++;
    end
  endtask

  task automatic push_ramp(input int first, input int last, input int step);
    for (int k = first; k != last + step; k += step) begin
      sp_q.push_back(SP_W'(k));
    end
  endtask

  // result watcher: register reads and every setpoint change while watch_sp is set
  always @(posedge clk_in) begin
    sp_last <= sp;
    if (rd_chk) begin
      compare(16'(rdata), 16'(rd_q.pop_front()));
    end
    if (watch_sp && sp !== sp_last) begin
      if (sp_q.size() == 0) begin
        compare(16'(sp), 16'hffff);
      end else begin
        compare(16'(sp), 16'(sp_q.pop_front()));
      end
      if (per_cyc != 0 && prev_t != 0) begin
        near(int'(($time - prev_t) / 50), per_cyc, 3);
      end
      prev_t = $time;
    end
  end

  initial begin
    #4_800_000;
    n_errors++;
    test_done();
  end

  initial begin
    reset_in = 1'b1;
    term = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    load = 8'h00;
    msel = 2'h0;
    void'($urandom(32'h33ac5860));
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    rd_reg(ADDR_TRACK, 8'h18);
    rd_reg(ADDR_OFF_DLY, 8'h0b);
    rd_reg(ADDR_ON_DLY, 8'h00);
    rd_reg(8'h20 + 8'($urandom % 8'hd0), 8'h00);
    wr_reg(ADDR_RUN, 8'hff);
    rd_reg(ADDR_RUN, 8'h00);
    wr_reg(ADDR_OFF_DLY, 8'hff);
    rd_reg(ADDR_OFF_DLY, 8'h3f);
    v = 8'($urandom);
    wr_reg(ADDR_ON_DLY, v);
    rd_reg(ADDR_ON_DLY, v);
    for (int c = 0; c < 8; c++) begin
      wr_reg(ADDR_TRACK, {1'b1, 3'(c), 1'b1, 3'(c)});
      rd_reg(ADDR_TRACK, {1'b0, 3'(c), 1'b1, 3'(c)});
    end
    wr_reg(ADDR_ON_DLY, 8'h00);
    // off delay keeps the pre-ramp wait positive; fast rise, no load
    wr_reg(ADDR_OFF_DLY, 8'h01);
    wr_reg(ADDR_TRACK, 8'h6a);
    wr_reg(ADDR_SP_FIRST, 8'h01);
    wr_reg(ADDR_SP_FIRST + 8'h01, 8'h00);
    $display("test registers done");
    watch_sp = 1'b1;
    push_ramp(4, 16, 4);
    per_cyc = 100;
    prev_t = 0;
    pm.send_cmd(1'b1);
    wait_for(1'b0, 1'b1, 10);
    near(n, 2, 2);
    compare(16'(sw), 16'h0001);
    wait_for(1'b0, 1'b0, 1000);
    repeat (200) @(negedge clk_in);
    compare(16'(sp), 16'h0010);
    compare(16'(sp_q.size()), 16'h0000);
    $display("test ramp up done");
    push_ramp(12, 0, -4);
    per_cyc = 1000;
    prev_t = 0;
    pm.send_cmd(1'b0);
    wait_for(1'b0, 1'b1, 20000);
    near(n, 16000, 30);
    wait_for(1'b1, 1'b0, 6000);
    near(n, 4000, 60);
    repeat (2) @(negedge clk_in);
    compare(16'(ramp), 16'h0000);
    $display("test ramp down done");
    wr_reg(ADDR_ON_DLY, 8'h01);
    push_ramp(4, 16, 4);
    per_cyc = 100;
    prev_t = 0;
    pm.send_cmd(1'b1);
    repeat (5000) @(negedge clk_in);
    pm.send_cmd(1'b0);
    repeat (5000) @(negedge clk_in);
    compare(16'(sw), 16'h0000);
    pm.send_cmd(1'b1);
    wait_for(1'b0, 1'b1, 22000);
    near(n, 20000, 30);
    wait_for(1'b0, 1'b0, 1000);
    compare(16'(ramp), 16'h0000);
    $display("test restart done");
    wr_reg(ADDR_TRACK, 8'h62);
    sp_q.push_back(12'h000);
    per_cyc = 0;
    pm.send_cmd(1'b0);
    wait_for(1'b1, 1'b0, 22000);
    near(n, 20000, 30);
    compare(16'(ramp), 16'h0000);
    $display("test hard off done");
    wr_reg(ADDR_ON_DLY, 8'h00);
    wr_reg(ADDR_SP_FIRST, 8'h14);
    wr_reg(ADDR_SP_FIRST + 8'h01, 8'h00);
    push_ramp(4, 320, 4);
    per_cyc = 100;
    prev_t = 0;
    pm.send_cmd(1'b1);
    wait_for(1'b0, 1'b1, 10);
    wait_for(1'b0, 1'b0, 9000);
    rd_reg(ADDR_RUN, 8'h01);
    per_cyc = 0;
    load = 8'hfa;
    for (int c = 1; c < 9; c++) begin
      sp_q.push_back(12'h140 - SP_W'(slope[c % 8]));
      wr_reg(ADDR_LOAD_REG, {3'(c), 5'h00});
      repeat (8) @(negedge clk_in);
      rd_reg(ADDR_LOAD_REG, {3'(c), 5'h00});
    end
    // second setpoint as a margin target, then select code 3 falls back
    wr_reg(ADDR_SP_FIRST + 8'h02, 8'h0c);
    wr_reg(ADDR_SP_FIRST + 8'h03, 8'h80);
    sp_q.push_back(12'h0c8);
    sp_q.push_back(12'h140);
    msel = 2'h1;
    repeat (4) @(negedge clk_in);
    msel = 2'h3;
    repeat (4) @(negedge clk_in);
    $display("test droop done");
    @(negedge clk_in);
    watch_sp = 1'b0;
    term = 1'b1;
    reset_in = 1'b1;
    repeat (2) @(negedge clk_in);
    reset_in = 1'b0;
    rd_reg(ADDR_TRACK, 8'h08);
    compare(16'(sp_q.size()), 16'h0000);
    $display("test terminator done");
    test_done();
  end
endmodule
